// *** dual_sub_alu.sv ***
// Dual 16-bit subtract ALU with its register file behind an AXI4-Lite slave.
// Assumes one clock (mclk, 25 MHz) and an AXI4-Lite master with 32-bit data.
module dual_sub_alu (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // AXI4-Lite write address and data.
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response.
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read channels.
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Interrupt.
  output logic irq
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Byte-lane merge of a bus write into an existing word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Widens a 16-bit word to the high lane, signed or zero filled.
  function automatic logic [23:0] sext24(input logic [15:0] v, input logic sx);
    return {(sx ? {8{v[15]}} : 8'h00), v};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dual_sub_pkg::modes_s modes_reg;
  dual_sub_pkg::form_e form_reg;
  dual_sub_pkg::state_e state_reg;
  dual_sub_pkg::lane_res_s res;
  logic [7:0] rpt_reg;
  logic [3:0] ptr_reg;
  logic [15:0] tmp_reg;
  logic [15:0] mem [0:dual_sub_pkg::MEM_DEPTH-1];
  logic [39:0] acc_reg [0:1];
  logic [1:0] ovf_reg;
  logic carry_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic wr_fire;
  logic exec;
  logic dst_idx;
  logic use_tmp;
  logic mem_first;
  logic [31:0] rd_data;
  logic rd_ok;
  logic wr_ok;
  logic [15:0] mem_hi_w;
  logic [15:0] mem_lo_w;
  logic [23:0] x_hi;
  logic [23:0] y_hi;
  logic [15:0] x_lo;
  logic [15:0] y_lo;
  logic [16:0] d_lo;
  logic [24:0] d_hi;
  logic [16:0] c31;
  logic cin;
  logic borrow_lo;
  logic sat_eff;

  assign wr_fire = aw_full_reg && w_full_reg && !bvalid;
  assign exec = (state_reg == dual_sub_pkg::ST_RUN);

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------

  // Address and data are caught in either order; the response waits for both.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      awready <= 1'h1;
      wready <= 1'h1;
      aw_full_reg <= 1'h0;
      w_full_reg <= 1'h0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid <= 1'h0;
      bresp <= dual_sub_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_addr_reg <= awaddr;
        aw_full_reg <= 1'h1;
        awready <= 1'h0;
      end
      if (wvalid && wready) begin
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
        w_full_reg <= 1'h1;
        wready <= 1'h0;
      end
      if (wr_fire) begin
        aw_full_reg <= 1'h0;
        w_full_reg <= 1'h0;
        bvalid <= 1'h1;
        bresp <= wr_ok ? dual_sub_pkg::RESP_OKAY : dual_sub_pkg::RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'h0;
        awready <= 1'h1;
        wready <= 1'h1;
      end
    end
  end

  // Writes above 0x28 outside the memory window get SLVERR; command and flag words are write targets too.
  always_comb begin
    wr_ok = (aw_addr_reg[7:6] == dual_sub_pkg::MEM_REGION) ||
            (aw_addr_reg <= dual_sub_pkg::OFS_IRQ_MASK);
  end

  // Read decode; the memory window occupies 0x40 to 0x7C.
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'h1;
    if (araddr[7:6] == dual_sub_pkg::MEM_REGION) begin
      rd_data = {16'h0000, mem[araddr[5:2]]};
    end else begin
      unique case (araddr)
        dual_sub_pkg::OFS_CTRL: rd_data = {28'h0000000, modes_reg};
        dual_sub_pkg::OFS_CMD: rd_data = {16'h0000, rpt_reg, 7'h00, exec};
        dual_sub_pkg::OFS_PTR: rd_data = {28'h0000000, ptr_reg};
        dual_sub_pkg::OFS_TMP: rd_data = {16'h0000, tmp_reg};
        dual_sub_pkg::OFS_ACC_LO: rd_data = acc_reg[0][31:0];
        dual_sub_pkg::OFS_ACC_HI: rd_data = {24'h000000, acc_reg[0][39:32]};
        8'(dual_sub_pkg::OFS_ACC_LO + dual_sub_pkg::OFS_ACC_STRIDE): rd_data = acc_reg[1][31:0];
        8'(dual_sub_pkg::OFS_ACC_HI + dual_sub_pkg::OFS_ACC_STRIDE): begin
          rd_data = {24'h000000, acc_reg[1][39:32]};
        end
        dual_sub_pkg::OFS_FLAGS: rd_data = {29'h0, carry_reg, ovf_reg};
        dual_sub_pkg::OFS_IRQ_STAT: rd_data = {30'h0, irq_stat_reg};
        dual_sub_pkg::OFS_IRQ_MASK: rd_data = {30'h0, irq_mask_reg};
        default: rd_ok = 1'h0;
      endcase
    end
  end

  // Reads answer one cycle after the address is taken.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      arready <= 1'h1;
      rvalid <= 1'h0;
      rdata <= 32'h0000_0000;
      rresp <= dual_sub_pkg::RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'h0;
        rvalid <= 1'h1;
        rdata <= rd_data;
        rresp <= rd_ok ? dual_sub_pkg::RESP_OKAY : dual_sub_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'h0;
        arready <= 1'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers and operand memory
  // ----------------------------------------------------------------

  // Mode bits, temporary register and pointer; the pointer walks two words per iteration.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      modes_reg <= dual_sub_pkg::CTRL_RESET;
      tmp_reg <= 16'h0000;
      ptr_reg <= dual_sub_pkg::PTR_RESET;
    end else begin
      if (wr_fire && aw_addr_reg == dual_sub_pkg::OFS_CTRL && w_strb_reg[0]) begin
        modes_reg <= w_data_reg[3:0];
      end
      if (wr_fire && aw_addr_reg == dual_sub_pkg::OFS_TMP) begin
        tmp_reg <= 16'(merge({16'h0000, tmp_reg}, w_data_reg, w_strb_reg));
      end
      if (exec) begin
        ptr_reg <= ptr_reg + 4'h2;
      end else if (wr_fire && aw_addr_reg == dual_sub_pkg::OFS_PTR && w_strb_reg[0]) begin
        ptr_reg <= w_data_reg[3:0];
      end
    end
  end

  // Operand memory holds no reset: software fills it before use.
  always_ff @(posedge mclk) begin
    if (wr_fire && aw_addr_reg[7:6] == dual_sub_pkg::MEM_REGION) begin
      if (w_strb_reg[0]) begin
        mem[aw_addr_reg[5:2]][7:0] <= w_data_reg[7:0];
      end
      if (w_strb_reg[1]) begin
        mem[aw_addr_reg[5:2]][15:8] <= w_data_reg[15:8];
      end
    end
  end

  // Command start; writes while a run is in flight are dropped.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg <= dual_sub_pkg::ST_IDLE;
      form_reg <= dual_sub_pkg::FORM_ACC_MINUS_MEM;
      rpt_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        dual_sub_pkg::ST_IDLE: begin
          if (wr_fire && aw_addr_reg == dual_sub_pkg::OFS_CMD && w_strb_reg[0]) begin
            form_reg <= dual_sub_pkg::form_e'(w_data_reg[dual_sub_pkg::CMD_FORM_LSB +: 2]);
            rpt_reg <= w_data_reg[dual_sub_pkg::CMD_RPT_LSB +: 8];
            state_reg <= dual_sub_pkg::ST_RUN;
          end
        end
        dual_sub_pkg::ST_RUN: begin
          if (rpt_reg == 8'h00) begin
            state_reg <= dual_sub_pkg::ST_IDLE;
          end else begin
            rpt_reg <= rpt_reg - 8'h01;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Dual-lane datapath
  // ----------------------------------------------------------------

  // Odd/even pairing of the double word is a flip of the pointer's lowest bit.
  assign mem_hi_w = mem[ptr_reg];
  assign mem_lo_w = mem[ptr_reg ^ 4'h1];

  // Operand routing per form; the destination is the second accumulator for acc forms.
  always_comb begin
    unique case (form_reg)
      dual_sub_pkg::FORM_ACC_MINUS_MEM: begin
        use_tmp = 1'h0;
        mem_first = 1'h0;
      end
      dual_sub_pkg::FORM_MEM_MINUS_ACC: begin
        use_tmp = 1'h0;
        mem_first = 1'h1;
      end
      dual_sub_pkg::FORM_TMP_MINUS_MEM: begin
        use_tmp = 1'h1;
        mem_first = 1'h0;
      end
      dual_sub_pkg::FORM_MEM_MINUS_TMP: begin
        use_tmp = 1'h1;
        mem_first = 1'h1;
      end
    endcase
    dst_idx = !use_tmp;
  end

  // Both lanes are computed in the same cycle; the low borrow crosses only in legacy single mode.
  always_comb begin
    x_hi = use_tmp ? sext24(tmp_reg, modes_reg.sign_extension_mode) : acc_reg[0][39:16];
    x_lo = use_tmp ? tmp_reg : acc_reg[0][15:0];
    y_hi = sext24(mem_hi_w, modes_reg.sign_extension_mode);
    y_lo = mem_lo_w;
    if (mem_first) begin
      {x_hi, y_hi} = {y_hi, x_hi};
      {x_lo, y_lo} = {y_lo, x_lo};
    end
    borrow_lo = ({1'h0, x_lo} < {1'h0, y_lo});
    cin = modes_reg.legacy_compat_mode && !modes_reg.dual_lane_carry_mode && borrow_lo;
    d_lo = {x_lo[15], x_lo} - {y_lo[15], y_lo};
    d_hi = {x_hi[23], x_hi} - {y_hi[23], y_hi} - {24'h000000, cin};
    c31 = {1'h0, x_hi[15:0]} - {1'h0, y_hi[15:0]} - {16'h0000, cin};
    sat_eff = modes_reg.data_saturation_mode && !modes_reg.legacy_compat_mode;
    res.carry = !c31[16];
    res.ovf_lo = (d_lo[16] ^ d_lo[15]) && !modes_reg.legacy_compat_mode;
    res.ovf_hi = !((&d_hi[24:15]) || !(|d_hi[24:15]));
    res.lo = d_lo[15:0];
    res.hi = d_hi[23:0];
    if (sat_eff && res.ovf_lo) begin
      res.lo = d_lo[16] ? dual_sub_pkg::SAT_LO_NEG : dual_sub_pkg::SAT_LO_POS;
    end
    if (sat_eff && res.ovf_hi) begin
      res.hi = d_hi[24] ? dual_sub_pkg::SAT_HI_NEG : dual_sub_pkg::SAT_HI_POS;
    end
  end

  // ----------------------------------------------------------------
  // Accumulators and their overflow flags
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_acc
    // The ALU result beats a software write landing in the same cycle.
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        acc_reg[g] <= 40'h00_0000_0000;
      end else if (exec && dst_idx == g[0]) begin
        acc_reg[g] <= {res.hi, res.lo};
      end else if (wr_fire && aw_addr_reg == 8'(dual_sub_pkg::OFS_ACC_LO + 8 * g)) begin
        acc_reg[g][31:0] <= merge(acc_reg[g][31:0], w_data_reg, w_strb_reg);
      end else if (wr_fire && aw_addr_reg == 8'(dual_sub_pkg::OFS_ACC_HI + 8 * g) &&
                   w_strb_reg[0]) begin
        acc_reg[g][39:32] <= w_data_reg[7:0];
      end
    end

    // Sticky overflow; a set in the clearing cycle wins.
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        ovf_reg[g] <= 1'h0;
      end else if (exec && dst_idx == g[0] && (res.ovf_hi || res.ovf_lo)) begin
        ovf_reg[g] <= 1'h1;
      end else if (wr_fire && aw_addr_reg == dual_sub_pkg::OFS_FLAGS && w_strb_reg[0] &&
                   w_data_reg[g]) begin
        ovf_reg[g] <= 1'h0;
      end
    end
  end

  // Carry reflects the last iteration only.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      carry_reg <= 1'h0;
    end else if (exec) begin
      carry_reg <= res.carry;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------

  // Done and overflow events are sticky, cleared by writing one; the set wins.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq_stat_reg <= dual_sub_pkg::IRQ_RESET;
      irq_mask_reg <= dual_sub_pkg::IRQ_RESET;
      irq <= 1'h0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (wr_fire && aw_addr_reg == dual_sub_pkg::OFS_IRQ_STAT && w_strb_reg[0] &&
            w_data_reg[b]) begin
          irq_stat_reg[b] <= 1'h0;
        end
      end
      if (exec && rpt_reg == 8'h00) begin
        irq_stat_reg[dual_sub_pkg::IRQ_DONE_BIT] <= 1'h1;
      end
      if (exec && (res.ovf_hi || res.ovf_lo)) begin
        irq_stat_reg[dual_sub_pkg::IRQ_OVF_BIT] <= 1'h1;
      end
      if (wr_fire && aw_addr_reg == dual_sub_pkg::OFS_IRQ_MASK && w_strb_reg[0]) begin
        irq_mask_reg <= w_data_reg[1:0];
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_both_lanes;
    exec |=> acc_reg[$past(dst_idx)] == {$past(res.hi), $past(res.lo)};
  endproperty
  a_both_lanes: assert property (p_both_lanes) else $error("Lane result not written.");

  property p_guard_hi;
    exec && !sat_eff && !cin |=> acc_reg[$past(dst_idx)][39:16] == $past(x_hi - y_hi);
  endproperty
  a_guard_hi: assert property (p_guard_hi) else $error("High lane wrong.");

  property p_wrap_lo;
    exec && !sat_eff |=> acc_reg[$past(dst_idx)][15:0] == $past(x_lo - y_lo);
  endproperty
  a_wrap_lo: assert property (p_wrap_lo) else $error("Low lane did not wrap.");

  property p_ovf_flag;
    exec && (res.ovf_hi || res.ovf_lo) |=> ovf_reg[$past(dst_idx)] ##1 irq_stat_reg[1];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("Overflow flag not set.");

  property p_carry;
    exec |=> carry_reg == !$past(c31[16]);
  endproperty
  a_carry: assert property (p_carry) else $error("Carry not from bit 31.");

  property p_sat_lo;
    exec && sat_eff && (d_lo[16] ^ d_lo[15]) |=>
      acc_reg[$past(dst_idx)][15:0] inside {16'h7FFF, 16'h8000};
  endproperty
  a_sat_lo: assert property (p_sat_lo) else $error("Low lane not clamped.");

  property p_legacy;
    exec && modes_reg.legacy_compat_mode |-> !res.ovf_lo && !sat_eff;
  endproperty
  a_legacy: assert property (p_legacy) else $error("Legacy mode saw low overflow.");

  property p_propagate;
    exec && modes_reg.legacy_compat_mode && !modes_reg.dual_lane_carry_mode && borrow_lo |=>
      acc_reg[$past(dst_idx)][39:16] == $past(x_hi - y_hi - 24'h000001);
  endproperty
  a_propagate: assert property (p_propagate) else $error("Borrow lost at bit 15.");

  property p_repeat;
    exec && rpt_reg != 8'h00 |=> exec && rpt_reg == $past(rpt_reg) - 8'h01;
  endproperty
  a_repeat: assert property (p_repeat) else $error("Repeat ended early.");

  c_mem_minus_acc_repeat: cover property (exec && form_reg == dual_sub_pkg::FORM_MEM_MINUS_ACC
                                          && rpt_reg == 8'h02);
  c_sat_hi: cover property (exec && sat_eff && res.ovf_hi);
  c_legacy_borrow: cover property (exec && cin);
  c_irq: cover property (irq);

endmodule

// *** dual_sub_pkg.sv ***
// Constants, types and register map of the dual 16-bit subtract ALU.
// Assumes a single 25 MHz clock domain and an AXI4-Lite master with 32-bit data.
package dual_sub_pkg;

  // ----------------------------------------------------------------
  // Datapath widths and clamp values
  // ----------------------------------------------------------------
  localparam int LO_W = 16;
  localparam int HI_W = 24;
  localparam int ACC_W = 40;
  localparam int MEM_DEPTH = 16;
  localparam logic [15:0] SAT_LO_POS = 16'h7FFF;
  localparam logic [15:0] SAT_LO_NEG = 16'h8000;
  localparam logic [23:0] SAT_HI_POS = 24'h007FFF;
  localparam logic [23:0] SAT_HI_NEG = 24'hFF8000;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_PTR = 8'h08;
  localparam logic [7:0] OFS_TMP = 8'h0C;
  localparam logic [7:0] OFS_ACC_LO = 8'h10;
  localparam logic [7:0] OFS_ACC_HI = 8'h14;
  localparam logic [7:0] OFS_ACC_STRIDE = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h20;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
  localparam logic [1:0] MEM_REGION = 2'h1;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CMD_FORM_LSB = 0;
  localparam int CMD_RPT_LSB = 8;
  localparam int FLAG_CARRY_BIT = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_OVF_BIT = 1;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [3:0] PTR_RESET = 4'h0;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FORM_ACC_MINUS_MEM, FORM_MEM_MINUS_ACC, FORM_TMP_MINUS_MEM, FORM_MEM_MINUS_TMP
  } form_e;
  typedef enum logic {ST_IDLE, ST_RUN} state_e;
  typedef struct packed {
    logic dual_lane_carry_mode;
    logic legacy_compat_mode;
    logic data_saturation_mode;
    logic sign_extension_mode;
  } modes_s;
  typedef struct packed {
    logic [23:0] hi;
    logic [15:0] lo;
    logic ovf_hi;
    logic ovf_lo;
    logic carry;
  } lane_res_s;

endpackage

// *** host_bus.sv ***
// AXI4-Lite master model standing for the host on the ALU's register bus.
// Assumes one rising-edge clock and one task call at a time from the bench.
module host_bus (
  // Clock.
  input wire logic mclk,
  // Write address and data.
  output logic awvalid,
  input wire logic awready,
  output logic [7:0] awaddr,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  // Write response.
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  // Read channels.
  output logic arvalid,
  input wire logic arready,
  output logic [7:0] araddr,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero so the slave never sees an unknown request.
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
  end

  // -------------------------------------------------------------
  // Transfers
  // -------------------------------------------------------------
  // The leading edge keeps a strobe from being assigned twice in one step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'h0;
        break;
      end
    end
  endtask

  // Read data are taken at the same edge that completes the handshake.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        break;
      end
    end
  endtask
endmodule

// *** testbench.sv ***
// Self-checking bench for the dual subtract ALU, driven over AXI4-Lite.
// Assumes host_bus as the bus master and the register map of the hand-over.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'h0;
  logic reset = 1'h1;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int errors = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h00000014;
  logic [15:0] memv [16];

  // 25 MHz clock.
  always #20 mclk = ~mclk;

  dual_sub_alu dut (.mclk, .reset, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
    .rdata, .rresp, .irq);
  host_bus host (.mclk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);

  // -------------------------------------------------------------
  // Helpers and reference model
  // -------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Limit values are favoured, since overflow only shows at the edges.
  function automatic logic [15:0] pick();
    logic [31:0] r;
    r = rnd();
    case (r[2:0])
      3'h0: return 16'h7FFF;
      3'h1: return 16'h8000;
      3'h2: return 16'h0000;
      default: return r[31:16];
    endcase
  endfunction

  // One iteration of a dual subtraction, both lanes at once.
  function automatic dual_sub_pkg::lane_res_s model(input logic [1:0] f,
      input dual_sub_pkg::modes_s m, input logic [15:0] mh, ml, t, input logic [39:0] ac);
    dual_sub_pkg::lane_res_s o;
    logic [23:0] mx, ox, a, b;
    logic [15:0] al, bl;
    logic [16:0] dl, cc;
    logic [24:0] dh;
    logic leg, sat, bi;
    leg = m.legacy_compat_mode;
    sat = m.data_saturation_mode && !leg;
    mx = m.sign_extension_mode ? {{8{mh[15]}}, mh} : {8'h00, mh};
    ox = !f[1] ? ac[39:16] : m.sign_extension_mode ? {{8{t[15]}}, t} : {8'h00, t};
    a = f[0] ? mx : ox;
    b = f[0] ? ox : mx;
    al = f[0] ? ml : (f[1] ? t : ac[15:0]);
    bl = f[0] ? (f[1] ? t : ac[15:0]) : ml;
    dl = {al[15], al} - {bl[15], bl};
    bi = leg && !m.dual_lane_carry_mode && (al < bl);
    dh = {a[23], a} - {b[23], b} - 25'(bi);
    cc = {1'h0, a[15:0]} - {1'h0, b[15:0]} - 17'(bi);
    o.carry = !cc[16];
    o.ovf_lo = !leg && (dl[16] != dl[15]);
    o.ovf_hi = !((&dh[24:15]) || !(|dh[24:15]));
    o.lo = (sat && o.ovf_lo) ? (dl[16] ? 16'h8000 : 16'h7FFF) : dl[15:0];
    o.hi = (sat && o.ovf_hi) ? (dh[24] ? 24'hFF8000 : 24'h007FFF) : dh[23:0];
    return o;
  endfunction

  task automatic chk(input string n, input logic [39:0] e, g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    logic [1:0] r;
    host.wr(a, d, r);
    chk("bresp", er, r);
  endtask

  task automatic r(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'h0);
    logic [1:0] s;
    host.rd(a, d, s);
    chk("rresp", er, s);
  endtask

  task automatic wrap_up();
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  // Random operands and modes cover every form; one form also repeats.
  initial begin
    logic [31:0] d, h;
    logic [1:0] f, msk;
    logic [3:0] p, pk;
    logic [15:0] t;
    logic [39:0] a1;
    logic [7:0] ba;
    logic [2:0] ef;
    int n;
    dual_sub_pkg::modes_s m;
    dual_sub_pkg::lane_res_s o;
    repeat (3) @(posedge mclk);
    reset <= 1'h0;
    r(dual_sub_pkg::OFS_CTRL, d);
    chk("ctrl_rst", 40'h0, d);
    r(dual_sub_pkg::OFS_IRQ_MASK, d);
    chk("mask_rst", 40'h0, d);
    r(8'h30, d, dual_sub_pkg::RESP_SLVERR);
    chk("unmapped", 40'h0, d);
    w(8'h34, 32'h1, dual_sub_pkg::RESP_SLVERR);
    for (int i = 0; i < 20; i++) begin
      d = rnd();
      f = 2'(i);
      m = dual_sub_pkg::modes_s'(d[3:0]);
      p = d[7:4];
      msk = d[9:8];
      n = (f == 2'h1) ? int'(d[11:10]) : 0;
      t = pick();
      a1 = {d[23:16], pick(), pick()};
      for (int k = 0; k < 16; k++) begin
        memv[k] = pick();
        w(8'h40 + 8'(4 * k), {16'h0000, memv[k]});
      end
      w(dual_sub_pkg::OFS_CTRL, {28'h0, m});
      w(dual_sub_pkg::OFS_PTR, {28'h0, p});
      w(dual_sub_pkg::OFS_TMP, {16'h0, t});
      w(dual_sub_pkg::OFS_ACC_LO, a1[31:0]);
      w(dual_sub_pkg::OFS_ACC_HI, {24'h0, a1[39:32]});
      w(dual_sub_pkg::OFS_FLAGS, 32'h3);
      w(dual_sub_pkg::OFS_IRQ_STAT, 32'h3);
      w(dual_sub_pkg::OFS_IRQ_MASK, {30'h0, msk});
      ef = 3'h0;
      for (int k = 0; k <= n; k++) begin
        pk = p + 4'(2 * k);
        o = model(f, m, memv[pk], memv[pk ^ 4'h1], t, a1);
        ef[f[1] ? 0 : 1] |= o.ovf_hi | o.ovf_lo;
        ef[2] = o.carry;
      end
      w(dual_sub_pkg::OFS_CMD, {16'h0, 8'(n), 6'h0, f});
      do r(dual_sub_pkg::OFS_CMD, d); while (d[0] === 1'h1);
      ba = dual_sub_pkg::OFS_ACC_LO + (f[1] ? 8'h00 : dual_sub_pkg::OFS_ACC_STRIDE);
      r(ba, d);
      r(ba + 8'h04, h);
      chk("acc", {o.hi, o.lo}, {h[7:0], d});
      r(dual_sub_pkg::OFS_FLAGS, d);
      chk("flags", 40'(ef), 40'(d[2:0]));
      r(dual_sub_pkg::OFS_PTR, d);
      chk("ptr", 40'(4'(p + 4'(2 * (n + 1)))), 40'(d[3:0]));
      if (!f[1]) begin
        r(dual_sub_pkg::OFS_ACC_LO, d);
        chk("src", a1[31:0], d);
      end
      #1;
      chk("irq", 40'(msk[0] | (msk[1] & (|ef[1:0]))), 40'(irq));
      w(dual_sub_pkg::OFS_IRQ_STAT, 32'h3);
      r(dual_sub_pkg::OFS_IRQ_STAT, d);
      #1;
      chk("irq_clr", 40'h0, 40'(irq));
    end
    wrap_up();
  end

  // Watchdog: far beyond the few thousand cycles the sequence needs.
  initial begin
    #2000000;
    errors++;
    wrap_up();
  end
endmodule
